// file: src/flash_cfg_pkg.sv
// Constants, types and opcode map for the serial flash register access block
// Notes on behaviour
// - Configuration read is served at all times, even during a write cycle.
// - Configuration read: opcode in, eight configuration bits out on serial output.
// - Bit 7 picks hold or reset pin function; both off when quad_enable is set.
// - Bits 6:5 pick read drive strength: full, half, three quarters, one and a half.
// - Bit 2 picks range protection or individual lock bit protection.
// - All individual block lock bits are set after power-on or any reset.
// - Bit 1 picks dummy clocks: 4 or 8 for two-IO, 6 or 10 for four-IO.
// - Learning pattern 00110100 drives during DTR dummy cycles when enabled.
// - Learning pattern enable is volatile and written by the configuration write.
// - Status and configuration writes need write_enable_latch set beforehand.
// - Status writes never change suspend, fail, enable latch or progress bits.
// - Status write runs only if chip select rises after 8 or 16 data bits.
// - Eight-bit 01H status write keeps the upper status byte unchanged; 31H keeps the lower byte.
// - Valid status write starts timed cycle; its end clears progress and latch.
// - Status writes are refused while hardware protection is in force.
// - Status write updates block_protect and status_protect under write-protect control.
// - Opcodes 01H with two bytes and 31H both write the status register.
// - Configuration write runs only if chip select rises after exactly 8 data bits.
// - Valid configuration write runs the timed cycle, then clears progress and latch.
// - Array read samples address on rising and shifts data on falling clock.
// - Array read: opcode, three address bytes, data streams until chip select rises.
// - Read address advances per byte and wraps to zero after the top address.
// - Writes are ignored while write_enable_latch is clear.
// - Status protect 0,1 with write-protect low locks both registers.
package flash_cfg_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_FREQ_MHZ = 200;
    localparam int NS_PER_US    = 1000;

    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_READ_ARRAY   = 8'h03;
    localparam logic [7:0] OP_READ_CONFIG  = 8'h15;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_WRITE_STAT_HI = 8'h31;
    localparam logic [7:0] OP_WRITE_CONFIG = 8'h11;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;

    // ==========================================================
    // Bit counts of a frame
    localparam logic [5:0] OPCODE_LAST  = 6'h07;
    localparam logic [5:0] ADDRESS_LAST = 6'h1f;
    localparam logic [5:0] OPCODE_BITS  = 6'h08;
    localparam logic [5:0] ONE_BYTE     = 6'h10;
    localparam logic [5:0] TWO_BYTES    = 6'h18;
    localparam logic [5:0] COUNT_MAX    = 6'h3f;
    localparam logic [2:0] BYTE_LAST    = 3'h7;

    // ==========================================================
    // Status register layout
    localparam int ST_WIP  = 0;
    localparam int ST_WEL  = 1;
    localparam int ST_SRP0 = 7;
    localparam int ST_STATUS_PROTECT = 8;
    localparam int ST_QE   = 9;
    localparam logic [15:0] STATUS_RESET   = 16'h0000;
    localparam logic [15:0] STATUS_RW_MASK = 16'h43fc;
    localparam logic [15:0] STATUS_OTP_MASK = 16'h3800;

    // ==========================================================
    // Configuration register layout
    localparam int CF_DLP = 0;
    localparam int CF_DC  = 1;
    localparam int CF_WPS = 2;
    localparam int CF_DRV_LO = 5;
    localparam int CF_DRV_HI = 6;
    localparam int CF_PIN = 7;
    localparam logic [7:0] CONFIG_RESET   = 8'h00;
    localparam logic [7:0] CONFIG_RW_MASK = 8'he7;

    // ==========================================================
    // Read option values
    localparam logic [3:0] DUMMY_2IO_SHORT = 4'h4;
    localparam logic [3:0] DUMMY_2IO_LONG  = 4'h8;
    localparam logic [3:0] DUMMY_4IO_SHORT = 4'h6;
    localparam logic [3:0] DUMMY_4IO_LONG  = 4'ha;
    localparam logic [7:0] LEARN_PATTERN   = 8'h34;
    localparam logic [7:0] NO_PATTERN      = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE        = 3'b000,
        ST_OPCODE      = 3'b001,
        ST_ADDRESS     = 3'b010,
        ST_READ_ARRAY  = 3'b011,
        ST_READ_CONFIG = 3'b100,
        ST_WRITE_DATA  = 3'b101,
        ST_IGNORE      = 3'b110
    } frame_state_e;

    typedef struct packed {
        logic chipSelectN;
        logic serialClk;
        logic serialIn;
        logic writeProtectN;
    } flash_pins_s;

    typedef struct packed {
        logic       holdEnable;
        logic       resetEnable;
        logic [1:0] driveStrength;
        logic       lockScheme;
        logic [3:0] dummy2io;
        logic [3:0] dummy4io;
        logic [7:0] dtrPattern;
    } read_options_s;

endpackage : flash_cfg_pkg

// file: src/byte_fifo.sv
// Small shift-register FIFO whose head sits in a register
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             clkEn,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [CW-1:0] ONE        = CW'(1);

    logic [WIDTH-1:0] entry [DEPTH];
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;

    assign inReady  = (count != FULL_COUNT);
    assign outValid = (count != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = entry[0];

    // ==========================================================
    // Occupancy
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            count <= '0;
        else if (clkEn)
        begin
            if (flush)
                count <= '0;
            else if (push && !pop)
                count <= count + ONE;
            else if (pop && !push)
                count <= count - ONE;
        end
    end

    // ==========================================================
    // Storage, shifting toward the head on each pop
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        localparam logic [CW-1:0] IDX  = CW'(i);
        localparam logic [CW-1:0] IDX1 = CW'(i + 1);
        logic [WIDTH-1:0] above;
        if (i < DEPTH - 1)
            assign above = entry[i+1];
        else
            assign above = entry[i];

        always_ff @(posedge ref_clk or negedge rst_b)
        begin
            if (!rst_b)
                entry[i] <= '0;
            else if (clkEn && !flush)
            begin
                if (pop)
                    entry[i] <= (push && count == IDX1) ? inData : above;
                else if (push && count == IDX)
                    entry[i] <= inData;
            end
        end
    end

endmodule : byte_fifo

// file: src/serial_flash_config_access.sv
// Serial flash command logic: configuration and status registers, single-bit array read
`timescale 1ns/100ps
module serial_flash_config_access
    import flash_cfg_pkg::*;
#(
    parameter int ADDR_W               = 24,
    parameter int NUM_LOCK_BITS        = 16,
    parameter int FIFO_DEPTH           = 4,
    parameter int STATUS_WRITE_TIME_NS = 1000000
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rst_b,
    input  wire logic                         clkEn,
    input  wire flash_cfg_pkg::flash_pins_s   flashPins,
    output logic                              serialOut,
    output logic                              serialOutEn,
    output logic                              arrayRdEn,
    output logic [ADDR_W-1:0]                 arrayAddr,
    input  wire logic [7:0]                   arrayRdData,
    input  wire logic                         arrayRdValid,
    output logic [15:0]                       statusReg,
    output logic [7:0]                        configReg,
    output logic [NUM_LOCK_BITS-1:0]          lockBits,
    output flash_cfg_pkg::read_options_s      readOptions
);
    import flash_cfg_pkg::*;

    // ==========================================================
    // Derived timing
    localparam int RAW_CYCLES   = STATUS_WRITE_TIME_NS * CLK_FREQ_MHZ / NS_PER_US;
    localparam int WRITE_CYCLES = (RAW_CYCLES < 1) ? 1 : RAW_CYCLES;
    localparam int TW           = $clog2(WRITE_CYCLES + 1);
    localparam logic [TW-1:0] WRITE_LOAD = TW'(WRITE_CYCLES - 1);
    localparam logic [TW-1:0] TIMER_ONE  = TW'(1);

    // ==========================================================
    // Status write merge: fixed bits kept, lock bits only set
    function automatic logic [15:0] mergeStatus(input logic [15:0] prev,
                                                input logic [15:0] wr);
        mergeStatus = (prev & ~(STATUS_RW_MASK | STATUS_OTP_MASK))
                    | (wr & STATUS_RW_MASK)
                    | ((prev | wr) & STATUS_OTP_MASK);
    endfunction : mergeStatus

    // ==========================================================
    // Pin synchronisers
    flash_pins_s   pinMeta;
    flash_pins_s   pinSync;
    logic          sclkPrev;
    logic          csPrev;
    logic          sclkRise;
    logic          sclkFall;
    logic          csRise;
    logic          csLow;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pinMeta <= '{chipSelectN: 1'b1, serialClk: 1'b0, serialIn: 1'b0,
                         writeProtectN: 1'b1};
            pinSync <= '{chipSelectN: 1'b1, serialClk: 1'b0, serialIn: 1'b0,
                         writeProtectN: 1'b1};
        end
        else if (clkEn)
        begin
            pinMeta <= flashPins;
            pinSync <= pinMeta;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclkPrev <= 1'b0;
            csPrev   <= 1'b1;
        end
        else if (clkEn)
        begin
            sclkPrev <= pinSync.serialClk;
            csPrev   <= pinSync.chipSelectN;
        end
    end

    assign csLow    = !pinSync.chipSelectN;
    assign sclkRise = csLow && pinSync.serialClk && !sclkPrev;
    assign sclkFall = csLow && !pinSync.serialClk && sclkPrev;
    assign csRise   = pinSync.chipSelectN && !csPrev;

    // ==========================================================
    // Frame state and input shifting
    frame_state_e  state;
    logic [5:0]    bitCount;
    logic [31:0]   rxShift;
    logic [7:0]    opcode;
    logic [31:0]   rxNext;

    assign rxNext = {rxShift[30:0], pinSync.serialIn};

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bitCount <= '0;
            rxShift  <= '0;
        end
        else if (clkEn)
        begin
            if (!csLow)
                bitCount <= '0;
            else if (sclkRise)
            begin
                rxShift <= rxNext;
                if (bitCount != COUNT_MAX)
                    bitCount <= bitCount + 6'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state  <= ST_IDLE;
            opcode <= '0;
        end
        else if (clkEn)
        begin
            if (!csLow)
                state <= ST_IDLE;
            else
            begin
                unique case (state)
                    ST_IDLE:
                        state <= ST_OPCODE;
                    ST_OPCODE:
                        if (sclkRise && bitCount == OPCODE_LAST)
                        begin
                            opcode <= rxNext[7:0];
                            unique case (rxNext[7:0])
                                OP_READ_ARRAY:   state <= ST_ADDRESS;
                                OP_READ_CONFIG:  state <= ST_READ_CONFIG;
                                OP_WRITE_STATUS,
                                OP_WRITE_STAT_HI,
                                OP_WRITE_CONFIG,
                                OP_WRITE_ENABLE: state <= ST_WRITE_DATA;
                                default:         state <= ST_IGNORE;
                            endcase
                        end
                    ST_ADDRESS:
                        if (sclkRise && bitCount == ADDRESS_LAST)
                            state <= ST_READ_ARRAY;
                    ST_READ_ARRAY,
                    ST_READ_CONFIG,
                    ST_WRITE_DATA,
                    ST_IGNORE:
                        state <= state;
                    default:
                        state <= ST_IGNORE;
                endcase
            end
        end
    end

    // ==========================================================
    // Array fetch into the FIFO
    logic          fetchPending;
    logic          fifoInReady;
    logic          fifoOutValid;
    logic          fifoPop;
    logic [7:0]    fifoHead;
    logic          addrLoad;

    assign addrLoad = sclkRise && state == ST_ADDRESS && bitCount == ADDRESS_LAST;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            arrayAddr    <= '0;
            arrayRdEn    <= 1'b0;
            fetchPending <= 1'b0;
        end
        else if (clkEn)
        begin
            arrayRdEn <= 1'b0;
            if (!csLow)
                fetchPending <= 1'b0;
            else if (addrLoad)
                arrayAddr <= rxNext[ADDR_W-1:0];
            else if (state == ST_READ_ARRAY && !fetchPending && !arrayRdEn
                     && fifoInReady)
            begin
                arrayRdEn    <= 1'b1;
                fetchPending <= 1'b1;
            end
            else if (arrayRdEn)
                arrayAddr <= arrayAddr + ADDR_W'(1);
            else if (arrayRdValid)
                fetchPending <= 1'b0;
        end
    end

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .clkEn    (clkEn),
        .flush    (!csLow),
        .inValid  (arrayRdValid && fetchPending && csLow),
        .inReady  (fifoInReady),
        .inData   (arrayRdData),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoHead)
    );

    // ==========================================================
    // Serial output on falling clock
    logic [2:0]    outBit;
    logic [7:0]    outShift;
    logic [7:0]    outByte;
    logic          readPhase;

    assign readPhase = (state == ST_READ_ARRAY) || (state == ST_READ_CONFIG);
    assign fifoPop   = sclkFall && state == ST_READ_ARRAY && outBit == '0;
    assign outByte   = (state == ST_READ_CONFIG) ? configReg
                     : (fifoOutValid ? fifoHead : 8'h00);

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serialOut   <= 1'b0;
            serialOutEn <= 1'b0;
            outBit      <= '0;
            outShift    <= '0;
        end
        else if (clkEn)
        begin
            if (!csLow)
            begin
                serialOutEn <= 1'b0;
                outBit      <= '0;
            end
            else if (sclkFall && readPhase)
            begin
                serialOutEn <= 1'b1;
                outBit      <= outBit + 3'h1;
                if (outBit == '0)
                begin
                    serialOut <= outByte[7];
                    outShift  <= {outByte[6:0], 1'b0};
                end
                else
                begin
                    serialOut <= outShift[7];
                    outShift  <= {outShift[6:0], 1'b0};
                end
            end
        end
    end

    // ==========================================================
    // Write commit at chip select rise
    logic          writeInProgress;
    logic          hwLocked;
    logic          mayWrite;
    logic          commitStatus;
    logic          commitConfig;
    logic          setEnable;
    logic [15:0]   next_status;
    logic [7:0]    next_config;
    logic [TW-1:0] writeTimer;
    logic          timerDone;

    assign writeInProgress = statusReg[ST_WIP];
    assign hwLocked = statusReg[ST_STATUS_PROTECT]
                    || (statusReg[ST_SRP0] && !pinSync.writeProtectN);
    assign mayWrite = csRise && state == ST_WRITE_DATA && statusReg[ST_WEL]
                    && !writeInProgress && !hwLocked;
    assign timerDone = writeInProgress && writeTimer == '0;

    always_comb
    begin
        commitStatus = 1'b0;
        commitConfig = 1'b0;
        setEnable    = 1'b0;
        next_status  = statusReg;
        next_config  = configReg;
        if (csRise && state == ST_WRITE_DATA && opcode == OP_WRITE_ENABLE
            && bitCount == OPCODE_BITS && !writeInProgress)
            setEnable = 1'b1;
        if (mayWrite)
        begin
            unique case (opcode)
                OP_WRITE_STATUS:
                    if (bitCount == ONE_BYTE)
                    begin
                        commitStatus = 1'b1;
                        next_status  = mergeStatus(statusReg,
                                                   {statusReg[15:8], rxShift[7:0]});
                    end
                    else if (bitCount == TWO_BYTES)
                    begin
                        commitStatus = 1'b1;
                        next_status  = mergeStatus(statusReg,
                                                   {rxShift[7:0], rxShift[15:8]});
                    end
                OP_WRITE_STAT_HI:
                    if (bitCount == ONE_BYTE)
                    begin
                        commitStatus = 1'b1;
                        next_status  = mergeStatus(statusReg,
                                                   {rxShift[7:0], statusReg[7:0]});
                    end
                OP_WRITE_CONFIG:
                    if (bitCount == ONE_BYTE)
                    begin
                        commitConfig = 1'b1;
                        next_config  = rxShift[7:0] & CONFIG_RW_MASK;
                    end
                default:
                    next_status = statusReg;
            endcase
        end
    end

    // ==========================================================
    // Self-timed write cycle
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            writeTimer <= '0;
        else if (clkEn)
        begin
            if (commitStatus || commitConfig)
                writeTimer <= WRITE_LOAD;
            else if (writeInProgress && writeTimer != '0)
                writeTimer <= writeTimer - TIMER_ONE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            statusReg <= STATUS_RESET;
        else if (clkEn)
        begin
            if (commitStatus)
            begin
                statusReg         <= next_status;
                statusReg[ST_WIP] <= 1'b1;
            end
            else if (commitConfig)
                statusReg[ST_WIP] <= 1'b1;
            else if (timerDone)
            begin
                statusReg[ST_WIP] <= 1'b0;
                statusReg[ST_WEL] <= 1'b0;
            end
            else if (setEnable)
                statusReg[ST_WEL] <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            configReg <= CONFIG_RESET;
        else if (clkEn && commitConfig)
            configReg <= next_config;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            lockBits <= '1;
        else if (clkEn)
            lockBits <= lockBits;
    end

    // ==========================================================
    // Decoded read options
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            readOptions <= '{holdEnable: 1'b1, resetEnable: 1'b0, driveStrength: 2'h0,
                             lockScheme: 1'b0, dummy2io: DUMMY_2IO_SHORT,
                             dummy4io: DUMMY_4IO_SHORT, dtrPattern: NO_PATTERN};
        else if (clkEn)
        begin
            readOptions.holdEnable  <= !statusReg[ST_QE] && !configReg[CF_PIN];
            readOptions.resetEnable <= !statusReg[ST_QE] && configReg[CF_PIN];
            readOptions.driveStrength <= {configReg[CF_DRV_HI], configReg[CF_DRV_LO]};
            readOptions.lockScheme  <= configReg[CF_WPS];
            readOptions.dummy2io    <= configReg[CF_DC] ? DUMMY_2IO_LONG
                                                        : DUMMY_2IO_SHORT;
            readOptions.dummy4io    <= configReg[CF_DC] ? DUMMY_4IO_LONG
                                                        : DUMMY_4IO_SHORT;
            readOptions.dtrPattern  <= configReg[CF_DLP] ? LEARN_PATTERN
                                                         : NO_PATTERN;
        end
    end

endmodule : serial_flash_config_access

// file: test/sfca_properties.sv
// Port checks for the flash register access block
`timescale 1ns/100ps
module sfca_properties
    import flash_cfg_pkg::*;
#(parameter int NUM_LOCK_BITS = 16) (
    input wire logic                     ref_clk,
    input wire logic                     rst_b,
    input wire logic [15:0]              statusReg,
    input wire logic [7:0]               configReg,
    input wire logic [NUM_LOCK_BITS-1:0] lockBits,
    input wire flash_cfg_pkg::read_options_s readOptions
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    sequence wipEnd;
        $fell(statusReg[0]);
    endsequence
    AST_LOCK: assert property (&lockBits) else $error("lock clear");
    AST_RSV: assert property (configReg[4:3] == 2'h0) else $error("reserved set");
    AST_FIX: assert property (!statusReg[15] && !statusReg[10]) else $error("ro bit");
    AST_END: assert property (wipEnd |-> !statusReg[1]) else $error("latch kept");
    AST_CFG: assert property (!$stable(configReg) |-> statusReg[0])
        else $error("config w/o cycle");
    AST_PAT: assert property (readOptions.dtrPattern == ($past(configReg[0]) ? 8'h34 : 8'h00))
        else $error("pattern");
    AST_DUM: assert property (readOptions.dummy4io == ($past(configReg[1]) ? 4'ha : 4'h6))
        else $error("dummy");
    AST_DRV: assert property (readOptions.driveStrength == $past(configReg[6:5]))
        else $error("drive");
    AST_PIN: assert property (readOptions.holdEnable == !($past(configReg[7]) || $past(statusReg[9])))
        else $error("hold pin");
endmodule : sfca_properties
bind serial_flash_config_access sfca_properties #(.NUM_LOCK_BITS(NUM_LOCK_BITS)) i_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .statusReg(statusReg), .configReg(configReg),
    .lockBits(lockBits), .readOptions(readOptions));

// file: test/spi_host_model.sv
// Controller side of the serial link, 48 ns link clock
`timescale 1ns/100ps
module spi_host_model
    import flash_cfg_pkg::*;
(
    output flash_cfg_pkg::flash_pins_s pins,
    input  wire logic                  serialOut
);
    initial pins = 4'b1001;
    // Clock stands still between frames; released input toggles
    task automatic frame(input logic [55:0] v, input int n, output logic [55:0] r);
        r = '0;
        pins.chipSelectN <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            pins.serialIn <= v[55-i];
            #24 pins.serialClk <= 1'b1;
            r = {r[54:0], serialOut};
            #24 pins.serialClk <= 1'b0;
        end
        #24 pins.chipSelectN <= 1'b1;
        pins.serialIn <= ~pins.serialIn;
        #100;
    endtask : frame
    task automatic setWp(input logic v);
        pins.writeProtectN <= v;
    endtask : setWp
endmodule : spi_host_model

// file: test/tb.sv
// Self-checking bench for the flash register access block
`timescale 1ns/100ps
module tb;
    import flash_cfg_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        arrayRdValid = 1'b0;
    logic [7:0]  arrayRdData = 8'h00;
    logic        arrayRdEn, serialOut, serialOutEn;
    logic        sawOe = 1'b0;
    logic [23:0] arrayAddr;
    logic [7:0]  configReg;
    logic [15:0] statusReg, lockBits;
    logic [55:0] rd;
    flash_pins_s pins;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        arrayRdValid <= arrayRdEn;
        arrayRdData <= arrayAddr[7:0] ^ 8'h5a;
        sawOe <= sawOe | serialOutEn;
    end
    serial_flash_config_access #(.STATUS_WRITE_TIME_NS(2000)) i_dut (.ref_clk(ref_clk),
        .rst_b(rst_b), .clkEn(1'b1), .flashPins(pins), .serialOut(serialOut),
        .serialOutEn(serialOutEn),
        .arrayRdEn(arrayRdEn), .arrayAddr(arrayAddr), .arrayRdData(arrayRdData),
        .arrayRdValid(arrayRdValid), .statusReg(statusReg), .configReg(configReg),
        .lockBits(lockBits), .readOptions());
    spi_host_model i_host (.pins(pins), .serialOut(serialOut));
    task automatic chk(input logic [55:0] s, input logic [55:0] e);
        samples_checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // Enable frame, write frame, then wait out the timed cycle
    task automatic wr(input logic [55:0] v, input int n);
        i_host.frame({8'h06, 48'h0}, 8, rd);
        i_host.frame(v, n, rd);
        #2200;
    endtask : wr
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        #50;
        chk({statusReg, configReg, lockBits}, {16'h0, 8'h0, 16'hffff});
        i_host.frame({8'h11, 8'hff, 40'h0}, 16, rd);
        chk(configReg, 8'h00);
        i_host.frame({8'h06, 48'h0}, 8, rd);
        i_host.frame({8'h11, 8'hff, 40'h0}, 15, rd);
        chk({statusReg, configReg}, 24'h000200);
        i_host.frame({8'h9f, 48'h0}, 16, rd);
        chk(sawOe, 1'b0);
        i_host.frame({8'h11, 8'hff, 40'h0}, 16, rd);
        i_host.frame({8'h15, 48'h0}, 24, rd);
        chk({statusReg, rd[15:0]}, 32'h0003e7e7);
        chk({sawOe, serialOutEn}, 2'b10);
        #1000;
        chk(statusReg, 16'h0000);
        $display("test config done");
        wr({8'h01, 8'hff, 40'h0}, 16);
        chk(statusReg, 16'h00fc);
        wr({8'h31, 8'h42, 40'h0}, 16);
        chk(statusReg, 16'h42fc);
        wr({8'h01, 8'h80, 8'h00, 32'h0}, 24);
        chk(statusReg, 16'h0080);
        wr({8'h01, 8'hff, 40'h0}, 12);
        chk(statusReg & 16'hfffd, 16'h0080);
        i_host.setWp(1'b0);
        wr({8'h31, 8'hff, 40'h0}, 16);
        wr({8'h11, 8'h00, 40'h0}, 16);
        chk({statusReg & 16'hfffd, configReg}, 24'h0080e7);
        i_host.setWp(1'b1);
        $display("test status done");
        i_host.frame({8'h03, 24'hffffff, 24'h0}, 56, rd);
        chk(rd[23:0], 24'ha55a5b);
        $display("test read done");
        finish_test();
    end
    initial
    begin
        #60000;
        n_mismatch++;
        finish_test();
    end
endmodule : tb
